// ===== mprs_pkg.sv
// Package of timing constants and states for the power/reset sequencer
`default_nettype none
package mprs_pkg;
  // Clock rate and millisecond tick
  localparam int unsigned CLK_HZ      = 40000000;
  localparam int unsigned MS_CYCLES   = CLK_HZ / 1000;
  localparam logic [15:0] MS_LAST     = 16'(MS_CYCLES - 1);
  // Pulse windows in milliseconds
  localparam logic [13:0] PON_MIN_MS  = 14'd100;
  localparam logic [13:0] PON_MAX_MS  = 14'd2000;
  localparam logic [13:0] POFF_MIN_MS = 14'd3000;
  localparam logic [13:0] POFF_MAX_MS = 14'd8000;
  localparam logic [13:0] RST_MIN_MS  = 14'd700;
  localparam logic [13:0] RST_MAX_MS  = 14'd1000;
  localparam logic [13:0] WIDTH_SAT   = 14'h3fff;
  // Sequencing step lengths in milliseconds
  localparam logic [13:0] BOOT_MS     = 14'd10;
  localparam logic [13:0] SHUT_MS     = 14'd10;
  localparam logic [13:0] RSTHOLD_MS  = 14'd10;

  typedef enum logic [2:0] {
    MPRS_OFF,
    MPRS_BOOT,
    MPRS_ON,
    MPRS_SHUT,
    MPRS_RESET
  } mprs_state_t;
endpackage
`default_nettype wire

// ===== mprs_sequencer.sv
// Power-key and reset-pulse sequencer of the cellular module
`default_nettype none
module mprs_sequencer #(
  // Clocks per millisecond tick; a bench may cut it to keep runs short
  parameter int unsigned TICK_CYCLES = mprs_pkg::MS_CYCLES
) (
  input  wire logic i_clk,            // 40 MHz clock
  input  wire logic i_resetn,         // Async reset, active low
  input  wire logic i_power_key_n,    // Power key, active low
  input  wire logic i_reset_n,        // Hardware reset pin, active low
  input  wire logic i_supply_ok,      // High while supply is at least 3.3 V
  input  wire logic i_soft_poweroff,  // One-cycle software power-off command
  input  wire logic i_soft_reset,     // One-cycle software reset command
  output logic      o_logic_rail_out, // Logic rail enable, high when powered
  output logic      o_core_reset_n,   // Core reset, active low
  output logic      o_shutdown_req,   // Orderly shutdown in progress
  output logic      o_abrupt_off      // Pulse: off without orderly steps
);

  mprs_pkg::mprs_state_t state_r, state_nxt;
  logic [15:0] div_r;
  logic        key_s1_r, key_s2_r, key_d_r;
  logic        rst_s1_r, rst_s2_r, rst_d_r;
  logic [13:0] key_ms_r, rst_ms_r, step_ms_r;
  logic        soft_off_r;
  logic        rail_r, core_rst_n_r, shut_r, abrupt_r;

  // Last divider count of one tick, cut to the divider width on purpose
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  // Saturating millisecond increment, shared by all three timers
  function automatic logic [13:0] ms_inc(input logic [13:0] v);
    ms_inc = (v == mprs_pkg::WIDTH_SAT) ? v : v + 14'h0001;
  endfunction

  function automatic logic in_win(input logic [13:0] v,
                                  input logic [13:0] lo,
                                  input logic [13:0] hi);
    in_win = (v >= lo) && (v <= hi);
  endfunction

  // Millisecond tick and release detection
  wire tick        = (div_r == TICK_LAST);
  wire key_release = key_s2_r && !key_d_r;
  wire rst_release = rst_s2_r && !rst_d_r;
  wire key_on_ok   = key_release &&
    in_win(key_ms_r, mprs_pkg::PON_MIN_MS, mprs_pkg::PON_MAX_MS);
  wire key_off_ok  = key_release &&
    in_win(key_ms_r, mprs_pkg::POFF_MIN_MS, mprs_pkg::POFF_MAX_MS);
  wire rst_ok      = rst_release &&
    in_win(rst_ms_r, mprs_pkg::RST_MIN_MS, mprs_pkg::RST_MAX_MS);
  // Each step has its own length; the first tick of a step may come at
  // any phase, so a step really lasts one tick less to its full length
  wire [13:0] step_len =
    (state_r == mprs_pkg::MPRS_SHUT)  ? mprs_pkg::SHUT_MS :
    (state_r == mprs_pkg::MPRS_RESET) ? mprs_pkg::RSTHOLD_MS :
                                        mprs_pkg::BOOT_MS;
  wire step_done   = (step_ms_r == step_len);

  // Two-stage synchronisers; first stage is read only by the second
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      key_s1_r <= 1'b1;
      key_s2_r <= 1'b1;
      key_d_r  <= 1'b1;
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
      rst_d_r  <= 1'b1;
    end
    else
    begin
      key_s1_r <= i_power_key_n;
      key_s2_r <= key_s1_r;
      key_d_r  <= key_s2_r;
      rst_s1_r <= i_reset_n;
      rst_s2_r <= rst_s1_r;
      rst_d_r  <= rst_s2_r;
    end
  end

  // Pulse-width timers count whole ms while the line is low
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_r    <= 16'h0000;
      key_ms_r <= 14'h0000;
      rst_ms_r <= 14'h0000;
    end
    else
    begin
      div_r    <= tick ? 16'h0000 : div_r + 16'h0001;
      key_ms_r <= key_s2_r ? 14'h0000 :
                  (tick ? ms_inc(key_ms_r) : key_ms_r);
      rst_ms_r <= rst_s2_r ? 14'h0000 :
                  (tick ? ms_inc(rst_ms_r) : rst_ms_r);
    end
  end

  // Next state; supply loss overrides every other event
  always_comb
  begin
    state_nxt = state_r;
    if (!i_supply_ok)
      state_nxt = mprs_pkg::MPRS_OFF;
    else
      unique case (state_r)
        mprs_pkg::MPRS_OFF:
          if (key_on_ok)
            state_nxt = mprs_pkg::MPRS_BOOT;
        mprs_pkg::MPRS_BOOT:
          if (step_done)
            state_nxt = mprs_pkg::MPRS_ON;
        mprs_pkg::MPRS_ON:
          if (key_off_ok || i_soft_poweroff)
            state_nxt = mprs_pkg::MPRS_SHUT;
          else if (rst_ok || i_soft_reset)
            state_nxt = mprs_pkg::MPRS_RESET;
        mprs_pkg::MPRS_SHUT:
          if (step_done)
            state_nxt = (soft_off_r && !key_s2_r) ?
                        mprs_pkg::MPRS_BOOT :
                        mprs_pkg::MPRS_OFF;
        mprs_pkg::MPRS_RESET:
          if (step_done)
            state_nxt = mprs_pkg::MPRS_BOOT;
      endcase
  end

  // State, step timer and registered outputs
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r      <= mprs_pkg::MPRS_OFF;
      step_ms_r    <= 14'h0000;
      soft_off_r   <= 1'b0;
      rail_r       <= 1'b0;
      core_rst_n_r <= 1'b0;
      shut_r       <= 1'b0;
      abrupt_r     <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      step_ms_r    <= (state_nxt != state_r) ? 14'h0000 :
                      (tick ? ms_inc(step_ms_r) : step_ms_r);
      soft_off_r   <= (state_r == mprs_pkg::MPRS_ON) ? i_soft_poweroff
                      && !key_off_ok : soft_off_r;
      rail_r       <= (state_nxt != mprs_pkg::MPRS_OFF);
      core_rst_n_r <= (state_nxt == mprs_pkg::MPRS_ON);
      shut_r       <= (state_nxt == mprs_pkg::MPRS_SHUT);
      abrupt_r     <= !i_supply_ok &&
                      (state_r != mprs_pkg::MPRS_OFF);
    end
  end

  assign o_logic_rail_out = rail_r;
  assign o_core_reset_n   = core_rst_n_r;
  assign o_shutdown_req   = shut_r;
  assign o_abrupt_off     = abrupt_r;

  // Checks; they rest while reset is applied
  chk_supply_off: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !i_supply_ok |=> !o_logic_rail_out && !o_shutdown_req)
    else $error("rail stays up after supply loss");
  chk_abrupt_once: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_abrupt_off |=> !o_abrupt_off)
    else $error("abrupt-off pulse lasts too long");
  chk_poweron_key: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == mprs_pkg::MPRS_OFF) && key_on_ok && i_supply_ok
    |=> o_logic_rail_out)
    else $error("valid key pulse did not power on");
  chk_short_ignored: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == mprs_pkg::MPRS_OFF) && key_release &&
    (key_ms_r < mprs_pkg::PON_MIN_MS) |=> !o_logic_rail_out)
    else $error("short key pulse powered on");
  chk_long_off: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == mprs_pkg::MPRS_ON) && key_off_ok && i_supply_ok
    |=> o_shutdown_req && o_logic_rail_out)
    else $error("long key pulse did not start shutdown");
  chk_hw_reset: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == mprs_pkg::MPRS_ON) && rst_ok && !key_off_ok &&
    !i_soft_poweroff && i_supply_ok |=> !o_core_reset_n)
    else $error("reset pulse did not reset core");
  chk_soft_reset: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == mprs_pkg::MPRS_ON) && i_soft_reset && !i_soft_poweroff &&
    !key_off_ok && i_supply_ok
    |=> state_r == mprs_pkg::MPRS_RESET)
    else $error("soft reset ignored");
  chk_soft_off: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == mprs_pkg::MPRS_ON) && i_soft_poweroff && i_supply_ok
    |=> o_shutdown_req)
    else $error("soft power-off ignored");
  // A running core or a shutdown in progress needs the rail up
  chk_rail_state: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (o_core_reset_n || o_shutdown_req) |-> o_logic_rail_out)
    else $error("core active with rail down");
  chk_key_restart: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (state_r == mprs_pkg::MPRS_SHUT) && step_done && soft_off_r &&
    !key_s2_r && i_supply_ok |=> state_r == mprs_pkg::MPRS_BOOT)
    else $error("held key did not restart");

  cov_power_on: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state_r == mprs_pkg::MPRS_BOOT ##1 state_r == mprs_pkg::MPRS_ON);
  cov_shutdown: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state_r == mprs_pkg::MPRS_SHUT ##1 state_r == mprs_pkg::MPRS_OFF);
  cov_reset: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state_r == mprs_pkg::MPRS_RESET ##1 state_r == mprs_pkg::MPRS_BOOT);
  cov_abrupt: cover property (@(posedge i_clk) disable iff (!i_resetn)
    o_abrupt_off);
  cov_restart: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state_r == mprs_pkg::MPRS_SHUT ##1 state_r == mprs_pkg::MPRS_BOOT);

endmodule
`default_nettype wire

// ===== mprs_host.sv
// Host model driving the power key and reset pins of the sequencer
`default_nettype none
module mprs_host (
  input  wire logic i_clk,       // Host clock
  input  wire logic i_supply_ok, // Supply stable as seen by the host
  output var logic  o_key_n,     // Power key drive, released high
  output var logic  o_rst_n      // Reset pin drive, released high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Scaled millisecond; must match the tick length the bench sets
  localparam int MS = 16;
  int unsigned supply_age = 0;
  // Pins idle released; the host drives them high from the start
  initial o_key_n = 1'b1;
  initial o_rst_n = 1'b1;
  // Age of stable supply, so no press lands on a settling rail
  always @(posedge i_clk)
    supply_age <= i_supply_ok ? supply_age + 1 : 0;
  // Low pulse of ms milliseconds on the key or the reset pin
  task automatic pulse(input bit on_key, input int ms);
    while (supply_age < 30 * MS) @(posedge i_clk);
    @(posedge i_clk);
    #2;
    if (on_key) o_key_n = 1'b0;
    else o_rst_n = 1'b0;
    repeat (ms * MS) @(posedge i_clk);
    #2;
    if (on_key) o_key_n = 1'b1;
    else o_rst_n = 1'b1;
  endtask
  // Key held at a level, used around a software power-off
  task automatic key_hold(input bit low);
    @(posedge i_clk);
    #2;
    o_key_n = !low;
  endtask
endmodule
`default_nettype wire

// ===== mprs_sequencer_tb_top.sv
// Self-checking testbench of the power/reset sequencer
`default_nettype none
module mprs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Scaled millisecond: a 16-clock tick keeps the long pulses affordable
  localparam int MS = 16;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       supply_ok = 1'b1;
  logic       soft_off = 1'b0;
  logic       soft_rst = 1'b0;
  logic       key_n;
  logic       pin_rst_n;
  wire  [3:0] outs;
  int         n_fail = 0;
  int         n_tests = 0;
  int         cyc = 0;
  mprs_host host (.i_clk(clk), .i_supply_ok(supply_ok),
    .o_key_n(key_n), .o_rst_n(pin_rst_n));
  mprs_sequencer #(.TICK_CYCLES(MS)) dut (.i_clk(clk), .i_resetn(resetn),
    .i_power_key_n(key_n), .i_reset_n(pin_rst_n),
    .i_supply_ok(supply_ok), .i_soft_poweroff(soft_off),
    .i_soft_reset(soft_rst), .o_logic_rail_out(outs[0]),
    .o_core_reset_n(outs[1]), .o_shutdown_req(outs[2]),
    .o_abrupt_off(outs[3]));
  initial forever #12.5 clk = ~clk;
  // Hang guard: the scenarios need about 74 thousand cycles in all
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 90000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic e, input logic g);
    n_tests++;
    if (e !== g)
    begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", name, e, g);
    end
  endtask
  // Bounded wait for output k to reach v, then judge it
  task automatic wait_for(input int k, input logic v, input int lim,
                          input string name);
    // Looked at just after each edge, once the outputs have settled
    for (int i = 0; i < lim && outs[k] !== v; i++)
    begin
      @(posedge clk);
      #2;
    end
    chk(name, v, outs[k]);
  endtask
  // One-cycle software command, power-off or reset
  task automatic cmd(input bit off);
    @(posedge clk);
    #2;
    if (off) soft_off = 1'b1;
    else soft_rst = 1'b1;
    @(posedge clk);
    #2;
    soft_off = 1'b0;
    soft_rst = 1'b0;
  endtask
  task automatic t_refused();
    host.pulse(1'b1, 2);
    host.pulse(1'b0, 1);
    repeat (10) @(posedge clk);
    #2;
    chk("rail", 1'b0, outs[0]);
  endtask
  task automatic t_power_on();
    host.pulse(1'b1, 150);
    wait_for(0, 1'b1, 8, "rail");
    // A step lasts 9 to 10 ms, as its first tick may come at any phase
    repeat (9 * MS - 20) @(posedge clk);
    #2;
    chk("core_reset_n", 1'b0, outs[1]);
    wait_for(1, 1'b1, 40, "core_reset_n");
  endtask
  task automatic t_soft_reset();
    cmd(1'b0);
    chk("core_reset_n", 1'b0, outs[1]);
    chk("rail", 1'b1, outs[0]);
    // Reset hold, then boot: two steps before the core runs again
    wait_for(1, 1'b1, 20 * MS + 40, "core_reset_n");
  endtask
  // The core must keep running while the pin is low and reset on release
  task automatic t_hw_reset();
    host.pulse(1'b0, 800);
    chk("core_reset_n", 1'b1, outs[1]);
    wait_for(1, 1'b0, 8, "core_reset_n");
    chk("rail", 1'b1, outs[0]);
    wait_for(1, 1'b1, 20 * MS + 40, "core_reset_n");
  endtask
  // Key left released, so the soft power-off must end in off
  task automatic t_soft_off();
    cmd(1'b1);
    chk("shutdown_req", 1'b1, outs[2]);
    wait_for(2, 1'b0, 10 * MS + 40, "shutdown_req");
    chk("rail", 1'b0, outs[0]);
  endtask
  task automatic t_long_off();
    host.pulse(1'b1, 3200);
    wait_for(2, 1'b1, 8, "shutdown_req");
    chk("rail", 1'b1, outs[0]);
    wait_for(2, 1'b0, 10 * MS + 40, "shutdown_req");
    chk("rail", 1'b0, outs[0]);
  endtask
  task automatic t_soft_off_reboot();
    host.key_hold(1'b1);
    cmd(1'b1);
    chk("shutdown_req", 1'b1, outs[2]);
    wait_for(2, 1'b0, 10 * MS + 40, "shutdown_req");
    chk("rail", 1'b1, outs[0]);
    host.key_hold(1'b0);
    wait_for(1, 1'b1, 10 * MS + 40, "core_reset_n");
  endtask
  // Brownout breaks the host's keep-supply duty on purpose
  task automatic t_brownout();
    @(posedge clk);
    #2;
    supply_ok = 1'b0;
    @(posedge clk);
    #2;
    chk("rail", 1'b0, outs[0]);
    chk("abrupt_off", 1'b1, outs[3]);
    @(posedge clk);
    #2;
    chk("abrupt_off", 1'b0, outs[3]);
    chk("shutdown_req", 1'b0, outs[2]);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #2;
    resetn = 1'b1;
    for (int k = 0; k < 4; k++) chk("reset out", 1'b0, outs[k]);
    t_refused();
    t_power_on();
    t_soft_reset();
    t_hw_reset();
    t_soft_off();
    t_power_on();
    t_long_off();
    t_power_on();
    t_soft_off_reboot();
    t_brownout();
    conclude();
  end
endmodule
`default_nettype wire
